// ==== include/fpe_pkg.sv ====
// Contract
// - phrase program is code 0x06, block at index 0, address index 1, data 2..5.
// - phrase program writes, reads back to verify, then sets completion.
// - program and one-time program need final index 5, else access error.
// - a command not allowed in the current mode raises access error.
// - phrase program with bad global address or misaligned phrase raises access error.
// - phrase program into a protected region raises protection violation.
// - verify sets error flag on any error, second flag on uncorrectable error.
// - one-time area is eight phrases in information area of program block 0.
// - one-time program is code 0x07, phrase index 0..7 at index 1, data 2..5.
// - one-time program checks erased first, then programs and verifies.
// - one-time phrase index beyond seven raises access error.
// - programming an already programmed one-time phrase raises access error.
// - a one-time phrase holding all ones may be programmed again.
// - reads of program block 0 are invalid while one-time program runs.
// - erase-all is code 0x08, erases and verifies, releases security on pass.
// - erase-all needs final index 0, else access error.
// - erase-all with any protected area raises protection violation.
// - block erase is code 0x09, block at index 0, address index 1.
// - block erase needs index 1 and a valid block, else access error.
// - block erase needs phrase alignment in program and word in data flash.
// - block erase of a block with protection raises protection violation.
package fpe_pkg;
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_INDEX = 4'h1;
   localparam logic [3:0] REG_WORD = 4'h2;
   localparam logic [3:0] REG_PROTECT = 4'h3;
   localparam logic [3:0] REG_MODE = 4'h4;
   localparam logic [3:0] REG_SECURE = 4'h5;
   localparam int ST_COMPLETE = 7;
   localparam int ST_ACCESS_ERROR_FLAG = 5;
   localparam int ST_PROTVIOL = 4;
   localparam int ST_VERR = 1;
   localparam int ST_VUNC = 0;
   localparam logic [7:0] CMD_PROG = 8'h06;
   localparam logic [7:0] CMD_OTP = 8'h07;
   localparam logic [7:0] CMD_ALL = 8'h08;
   localparam logic [7:0] CMD_BLK = 8'h09;
   localparam logic [2:0] IDX_PROG = 3'h5;
   localparam logic [2:0] IDX_OTP = 3'h5;
   localparam logic [2:0] IDX_ALL = 3'h0;
   localparam logic [2:0] IDX_BLK = 3'h1;
   localparam logic [2:0] IDX_LAST = 3'h5;
   localparam logic [6:0] PF_BLK0 = 7'h7F;
   localparam logic [6:0] PF_BLK1 = 7'h7E;
   localparam logic [6:0] DF_BLK = 7'h10;
   localparam logic [15:0] OTP_MAX = 16'h0007;
   localparam logic [63:0] ERASED = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [3:0] RST_MODE = 4'hF;
   localparam logic [2:0] RST_PROTECT = 3'h0;
   localparam logic RST_SECURED = 1'b1;
   typedef enum logic [2:0] {
      OP_READ = 3'b000, OP_PROG = 3'b001, OP_ERASE_BLK = 3'b010, OP_ERASE_ALL = 3'b011,
      OP_EVER_BLK = 3'b100, OP_EVER_ALL = 3'b101, OP_PROG_OTP = 3'b110, OP_READ_OTP = 3'b111
   } fpe_op_type;
   typedef struct packed {
      logic req;
      fpe_op_type op;
      logic [22:0] addr;
      logic [63:0] data;
   } fpe_arr_req_type;
   typedef struct packed {
      logic done;
      logic [63:0] rdata;
      logic eccErr;
      logic fail;
   } fpe_arr_rsp_type;
endpackage

// ==== core/fpe_sequencer.sv ====
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module fpe_sequencer
   import fpe_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdata,
   output fpe_arr_req_type arrReq,
   input wire fpe_arr_rsp_type arrRsp,
   output logic blk0ReadInvalid,
   output logic secured
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_CHECK = 3'b001, S_OTP_RD = 3'b010, S_ERASE = 3'b011,
      S_PROG = 3'b100, S_READ = 3'b101, S_EVER = 3'b110, S_DONE = 3'b111
   } fpe_state_type;

   fpe_state_type state, next_state;
   logic [15:0] cmdWord [0:5];
   logic [2:0] cmdIndex;
   logic [2:0] protect;
   logic [3:0] modeMask;
   logic complete, accessError, protViol, verifyError, verifyUncorr;
   logic issued;
   logic chkAcc, chkProt;
   logic otpUsed;
   logic [7:0] cmd;
   logic [6:0] blk;
   logic [22:0] gAddr;
   logic [63:0] phrase;
   logic busyWrite;
   logic launch;

   function automatic logic isPflash(input logic [6:0] b);
      return (b == PF_BLK0) || (b == PF_BLK1);
   endfunction

   function automatic logic blkProt(input logic [6:0] b, input logic [2:0] p);
      return ((b == PF_BLK0) && p[0]) || ((b == PF_BLK1) && p[1]) || ((b == DF_BLK) && p[2]);
   endfunction

   assign cmd = cmdWord[0][15:8];
   assign blk = cmdWord[0][6:0];
   assign gAddr = {blk, cmdWord[1]};
   assign phrase = {cmdWord[5], cmdWord[4], cmdWord[3], cmdWord[2]};
   assign busyWrite = regWrite && !complete;
   assign launch = regWrite && (regAddr == REG_STATUS) && regWdata[ST_COMPLETE] && complete
                   && !accessError && !protViol;

   // launch checks
   always_comb begin
      chkAcc = 1'b0;
      chkProt = 1'b0;
      case (cmd)
         CMD_PROG: begin
            chkAcc = (cmdIndex != IDX_PROG) || !modeMask[0] || !isPflash(blk)
                     || cmdWord[0][7] || (cmdWord[1][2:0] != 3'h0);
            chkProt = blkProt(blk, protect);
         end
         CMD_OTP: begin
            chkAcc = (cmdIndex != IDX_OTP) || !modeMask[1]
                     || (cmdWord[1] > OTP_MAX);
         end
         CMD_ALL: begin
            chkAcc = (cmdIndex != IDX_ALL) || !modeMask[2];
            chkProt = |protect;
         end
         CMD_BLK: begin
            chkAcc = (cmdIndex != IDX_BLK) || !modeMask[3] || cmdWord[0][7]
                     || !(isPflash(blk) || (blk == DF_BLK));
            if (isPflash(blk) && (cmdWord[1][2:0] != 3'h0)) begin
               chkAcc = 1'b1;
            end
            if ((blk == DF_BLK) && cmdWord[1][0]) begin
               chkAcc = 1'b1;
            end
            chkProt = blkProt(blk, protect);
         end
         default: begin
            chkAcc = 1'b1;
         end
      endcase
      if (chkAcc) begin
         chkProt = 1'b0;
      end
   end

   assign otpUsed = (arrRsp.rdata != ERASED);

   // sequencing
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (launch) begin
               next_state = S_CHECK;
            end
         end
         S_CHECK: begin
            if (chkAcc || chkProt) begin
               next_state = S_DONE;
            end else if (cmd == CMD_OTP) begin
               next_state = S_OTP_RD;
            end else if (cmd == CMD_PROG) begin
               next_state = S_PROG;
            end else begin
               next_state = S_ERASE;
            end
         end
         S_OTP_RD: begin
            if (arrRsp.done) begin
               next_state = otpUsed ? S_DONE : S_PROG;
            end
         end
         S_PROG: begin
            if (arrRsp.done) begin
               next_state = S_READ;
            end
         end
         S_ERASE: begin
            if (arrRsp.done) begin
               next_state = S_EVER;
            end
         end
         S_READ, S_EVER: begin
            if (arrRsp.done) begin
               next_state = S_DONE;
            end
         end
         S_DONE: begin
            next_state = S_IDLE;
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // array requests, one pulse per operation state
   always_ff @(posedge core_clk) begin
      if (srst) begin
         arrReq <= '0;
         issued <= 1'b0;
      end else begin
         arrReq.req <= 1'b0;
         if (arrRsp.done) begin
            issued <= 1'b0;
         end else if (!issued && (state inside {S_OTP_RD, S_PROG, S_ERASE, S_READ, S_EVER})) begin
            issued <= 1'b1;
            arrReq.req <= 1'b1;
            arrReq.data <= phrase;
            arrReq.addr <= (cmd == CMD_OTP) ? {20'h0, cmdWord[1][2:0]} : gAddr;
            case (state)
               S_OTP_RD: arrReq.op <= OP_READ_OTP;
               S_PROG: arrReq.op <= (cmd == CMD_OTP) ? OP_PROG_OTP : OP_PROG;
               S_READ: arrReq.op <= (cmd == CMD_OTP) ? OP_READ_OTP : OP_READ;
               S_ERASE: arrReq.op <= (cmd == CMD_ALL) ? OP_ERASE_ALL : OP_ERASE_BLK;
               default: arrReq.op <= (cmd == CMD_ALL) ? OP_EVER_ALL : OP_EVER_BLK;
            endcase
         end
      end
   end

   // completion flag
   always_ff @(posedge core_clk) begin
      if (srst) begin
         complete <= 1'b1;
      end else if (launch) begin
         complete <= 1'b0;
      end else if (state == S_DONE) begin
         complete <= 1'b1;
      end
   end

   // error flags, hardware set wins over software clear
   always_ff @(posedge core_clk) begin
      if (srst) begin
         accessError <= 1'b0;
         protViol <= 1'b0;
      end else begin
         if (regWrite && (regAddr == REG_STATUS) && complete) begin
            if (regWdata[ST_ACCESS_ERROR_FLAG]) begin
               accessError <= 1'b0;
            end
            if (regWdata[ST_PROTVIOL]) begin
               protViol <= 1'b0;
            end
         end
         if ((state == S_CHECK) && chkAcc) begin
            accessError <= 1'b1;
         end
         if ((state == S_OTP_RD) && arrRsp.done && otpUsed) begin
            accessError <= 1'b1;
         end
         if ((state == S_CHECK) && chkProt) begin
            protViol <= 1'b1;
         end
      end
   end

   // verify flags
   always_ff @(posedge core_clk) begin
      if (srst) begin
         verifyError <= 1'b0;
         verifyUncorr <= 1'b0;
      end else if (launch) begin
         verifyError <= 1'b0;
         verifyUncorr <= 1'b0;
      end else if (arrRsp.done && (state == S_READ)) begin
         verifyError <= (arrRsp.rdata != phrase) || arrRsp.eccErr || arrRsp.fail;
         verifyUncorr <= arrRsp.eccErr;
      end else if (arrRsp.done && (state == S_EVER)) begin
         verifyError <= arrRsp.fail || arrRsp.eccErr;
         verifyUncorr <= arrRsp.eccErr;
      end
   end

   // security release
   always_ff @(posedge core_clk) begin
      if (srst) begin
         secured <= RST_SECURED;
      end else if ((state == S_EVER) && arrRsp.done && (cmd == CMD_ALL)
                   && !arrRsp.fail && !arrRsp.eccErr) begin
         secured <= 1'b0;
      end
   end

   // block 0 reads invalid during one-time program
   always_ff @(posedge core_clk) begin
      if (srst) begin
         blk0ReadInvalid <= 1'b0;
      end else begin
         blk0ReadInvalid <= (next_state != S_IDLE) && (next_state != S_CHECK)
                            && (cmd == CMD_OTP);
      end
   end

   // command object and configuration registers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cmdIndex <= 3'h0;
         protect <= RST_PROTECT;
         modeMask <= RST_MODE;
      end else if (regWrite && !busyWrite) begin
         case (regAddr)
            REG_INDEX: cmdIndex <= regWdata[2:0];
            REG_PROTECT: protect <= regWdata[2:0];
            REG_MODE: modeMask <= regWdata[3:0];
            default: begin
            end
         endcase
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_word
         always_ff @(posedge core_clk) begin
            if (srst) begin
               cmdWord[gi] <= 16'h0000;
            end else if (regWrite && !busyWrite && (regAddr == REG_WORD)
                         && (cmdIndex == 3'(gi))) begin
               cmdWord[gi] <= regWdata;
            end
         end
      end
   endgenerate

   // read port
   always_ff @(posedge core_clk) begin
      if (srst) begin
         regRdata <= 16'h0000;
      end else if (regRead) begin
         case (regAddr)
            REG_STATUS: regRdata <= {8'h00, complete, 1'b0, accessError, protViol,
                                     2'b00, verifyError, verifyUncorr};
            REG_INDEX: regRdata <= {13'h0000, cmdIndex};
            REG_WORD: regRdata <= (cmdIndex <= IDX_LAST) ? cmdWord[cmdIndex] : 16'h0000;
            REG_PROTECT: regRdata <= {13'h0000, protect};
            REG_MODE: regRdata <= {12'h000, modeMask};
            REG_SECURE: regRdata <= {15'h0000, secured};
            default: regRdata <= 16'h0000;
         endcase
      end else begin
         regRdata <= 16'h0000;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   a_launch_clears: assert property (launch |=> !complete && (state == S_CHECK))
      else $error("launch did not clear completion");
   a_check_abort: assert property ((state == S_CHECK) && chkAcc
      |=> accessError ##1 complete && (state == S_IDLE))
      else $error("access error not reported with completion");
   a_prot_abort: assert property ((state == S_CHECK) && chkProt |=> protViol)
      else $error("protection violation not reported");
   a_no_array_err: assert property ((state == S_CHECK) && (chkAcc || chkProt)
      |=> !arrReq.req [*3])
      else $error("array touched after failed check");
   a_prog_index: assert property ((state == S_CHECK) && (cmd == CMD_PROG)
      && (cmdIndex != IDX_PROG) |=> accessError)
      else $error("bad index not flagged");
   a_align_check: assert property ((state == S_CHECK) && (cmd == CMD_PROG)
      && (cmdWord[1][2:0] != 3'h0) |=> accessError && (state == S_DONE))
      else $error("misaligned phrase accepted");
   a_otp_used: assert property ((state == S_OTP_RD) && arrRsp.done && otpUsed
      |=> accessError ##1 complete)
      else $error("reprogram of one-time phrase accepted");
   a_otp_erased: assert property ((state == S_OTP_RD) && arrRsp.done && !otpUsed
      |=> (state == S_PROG))
      else $error("erased one-time phrase not programmed");
   a_otp_range: assert property ((state == S_CHECK) && (cmd == CMD_OTP)
      && (cmdWord[1] > OTP_MAX) |=> accessError)
      else $error("one-time phrase index out of range accepted");
   a_mode_refuse: assert property ((state == S_CHECK) && (cmd == CMD_PROG)
      && !modeMask[0] |=> accessError)
      else $error("command allowed in wrong mode");
   a_all_index: assert property ((state == S_CHECK) && (cmd == CMD_ALL)
      && (cmdIndex != IDX_ALL) |=> accessError && (state == S_DONE))
      else $error("erase-all bad index accepted");
   a_all_prot: assert property ((state == S_CHECK) && (cmd == CMD_ALL)
      && (|protect) && !chkAcc |=> protViol)
      else $error("erase-all with protection accepted");
   a_blk_index: assert property ((state == S_CHECK) && (cmd == CMD_BLK)
      && (cmdIndex != IDX_BLK) |=> accessError)
      else $error("block erase bad index accepted");
   a_blk_align: assert property ((state == S_CHECK) && (cmd == CMD_BLK)
      && isPflash(blk) && (cmdWord[1][2:0] != 3'h0) |=> accessError)
      else $error("block erase misaligned address accepted");
   a_erase_verify: assert property ((state == S_ERASE) && arrRsp.done
      |=> (state == S_EVER))
      else $error("erase not followed by verify");
   a_verify_miss: assert property ((state == S_READ) && arrRsp.done
      && (arrRsp.rdata != phrase) |=> verifyError)
      else $error("verify mismatch not flagged");
   a_verify_unc: assert property (((state == S_READ) || (state == S_EVER))
      && arrRsp.done && arrRsp.eccErr |=> verifyError && verifyUncorr)
      else $error("uncorrectable verify error lost");
   a_secure_free: assert property ((state == S_EVER) && arrRsp.done
      && (cmd == CMD_ALL) && !arrRsp.fail && !arrRsp.eccErr |=> !secured)
      else $error("security not released");
   a_otp_invalid: assert property ((state inside {S_OTP_RD, S_PROG, S_READ})
      && (cmd == CMD_OTP) |-> blk0ReadInvalid)
      else $error("block 0 reads not invalid during one-time program");
   a_busy_hold: assert property (busyWrite && (regAddr == REG_INDEX)
      |=> $stable(cmdIndex))
      else $error("register changed while busy");
   a_prog_order: assert property ((state == S_PROG) && arrRsp.done
      |=> (state == S_READ) ##[1:1000] (state == S_DONE))
      else $error("program not followed by verify");
   a_done_complete: assert property ((state == S_DONE) |=> complete)
      else $error("completion not set after done");

   c_prog_ok: cover property ((state == S_READ) && arrRsp.done && !verifyError ##2 complete);
   c_otp_refused: cover property ((state == S_OTP_RD) && arrRsp.done && otpUsed);
   c_otp_prog: cover property ((state == S_PROG) && (cmd == CMD_OTP) && arrRsp.done);
   c_erase_all: cover property ($fell(secured));
   c_blk_prot: cover property ((state == S_CHECK) && (cmd == CMD_BLK) && chkProt);
endmodule // fpe_sequencer

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
   import fpe_pkg::*;
   logic core_clk;
   logic srst;
   logic [3:0] regAddr;
   logic [15:0] regWdata;
   logic regWrite;
   logic regRead;
   logic [15:0] regRdata;
   fpe_arr_req_type arrReq;
   fpe_arr_rsp_type arrRsp;
   logic blk0ReadInvalid;
   logic secured;
   int nMismatch;
   int checksDone;
   int respDelay;
   int cnt;
   logic respEcc;
   logic respFail;
   logic progSeen;
   logic invSeen;
   logic [63:0] lastData;
   logic [63:0] flip;
   logic [63:0] otpRead;
   logic [15:0] st;
   fpe_arr_req_type opLog[$];
   logic [3:0] rstAddr[7] = '{REG_STATUS, REG_INDEX, REG_PROTECT, REG_MODE, REG_SECURE, 4'h6, 4'hF};
   logic [15:0] rstVal[7] = '{16'h0080, 16'h0000, 16'h0000, 16'h000F, 16'h0001, 16'h0000, 16'h0000};
   logic [7:0] mCode[5] = '{CMD_PROG, CMD_OTP, CMD_ALL, CMD_BLK, 8'h0A};
   logic [2:0] mIdx[5] = '{IDX_PROG, IDX_OTP, IDX_ALL, IDX_BLK, 3'h0};

   fpe_sequencer fpe_sequencer_inst (
      .core_clk(core_clk),
      .srst(srst),
      .regAddr(regAddr),
      .regWdata(regWdata),
      .regWrite(regWrite),
      .regRead(regRead),
      .regRdata(regRdata),
      .arrReq(arrReq),
      .arrRsp(arrRsp),
      .blk0ReadInvalid(blk0ReadInvalid),
      .secured(secured)
   );

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // array stand-in: one done per request, read data churns while idle
   always @(posedge core_clk) begin
      arrRsp.done <= 1'b0;
      arrRsp.eccErr <= 1'b0;
      arrRsp.fail <= 1'b0;
      arrRsp.rdata <= ~arrRsp.rdata;
      if (arrReq.req === 1'b1) begin
         opLog.push_back(arrReq);
         cnt = respDelay;
         if (arrReq.op == OP_PROG || arrReq.op == OP_PROG_OTP) begin
            lastData = arrReq.data;
            progSeen = 1'b1;
         end
         if (arrReq.op == OP_PROG_OTP)
            invSeen = blk0ReadInvalid;
      end else if (cnt > 0) begin
         cnt = cnt - 1;
         if (cnt == 0) begin
            arrRsp.done <= 1'b1;
            arrRsp.eccErr <= respEcc;
            arrRsp.fail <= respFail;
            arrRsp.rdata <= progSeen ? lastData ^ flip : otpRead;
         end
      end
   end

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checksDone++;
      if (seen !== exp) begin
         nMismatch++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1;
      d = regRdata;
   endtask

   // load the command object, launch, poll for completion, check status and array traffic
   task automatic cmd(input logic [7:0] code, input logic [6:0] blk, input logic [15:0] w1,
         input logic [63:0] ph, input logic [2:0] idx, input logic [15:0] expSt, input int nOps);
      wr(REG_STATUS, 16'h0030);
      wr(REG_INDEX, 16'h0000);
      wr(REG_WORD, {code, 1'b0, blk});
      wr(REG_INDEX, 16'h0001);
      wr(REG_WORD, w1);
      for (int i = 0; i < 4; i++) begin
         wr(REG_INDEX, 16'(i + 2));
         wr(REG_WORD, ph[16*i +: 16]);
      end
      wr(REG_INDEX, {13'h0000, idx});
      opLog.delete();
      progSeen = 1'b0;
      wr(REG_STATUS, 16'h0080);
      for (int k = 0; k < 300; k++) begin // only reads while busy
         rd(REG_STATUS, st);
         if (st[ST_COMPLETE] === 1'b1)
            break;
      end
      chk(st, expSt);
      chk(opLog.size(), nOps);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checksDone, nMismatch);
      if (nMismatch == 0 && checksDone > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      #500000;
      nMismatch++;
      results();
   end

   initial begin
      srst = 1'b1;
      regAddr = 4'h0;
      regWdata = 16'h0000;
      regWrite = 1'b0;
      regRead = 1'b0;
      arrRsp = '0;
      respDelay = 1;
      cnt = 0;
      respEcc = 1'b0;
      respFail = 1'b0;
      progSeen = 1'b0;
      invSeen = 1'b0;
      lastData = '0;
      flip = '0;
      otpRead = ERASED;
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      wr(4'h6, 16'hFFFF);
      for (int i = 0; i < 7; i++) begin
         rd(rstAddr[i], st);
         chk(st, rstVal[i]);
      end
      chk(secured, 1'b1);
      wr(REG_INDEX, 16'h0006);
      rd(REG_WORD, st);
      chk(st, 16'h0000);
      // good phrase program against a slow array
      respDelay = 6;
      cmd(CMD_PROG, PF_BLK1, 16'h0010, 64'h0123_4567_89AB_CDEF, IDX_PROG, 16'h0080, 2);
      chk(opLog[0].op, OP_PROG);
      chk(opLog[0].addr, {PF_BLK1, 16'h0010});
      chk(opLog[0].data, 64'h0123_4567_89AB_CDEF);
      chk(opLog[1].op, OP_READ);
      respDelay = 1;
      flip = 64'h0000_0000_0000_0100;
      cmd(CMD_PROG, PF_BLK0, 16'h0020, 64'h0, IDX_PROG, 16'h0082, 2);
      flip = '0;
      respEcc = 1'b1;
      cmd(CMD_PROG, PF_BLK0, 16'h0028, 64'h0, IDX_PROG, 16'h0083, 2);
      respEcc = 1'b0;
      cmd(CMD_PROG, PF_BLK1, 16'h0010, ERASED, 3'h4, 16'h00A0, 0);
      cmd(CMD_PROG, PF_BLK1, 16'h0013, ERASED, IDX_PROG, 16'h00A0, 0);
      cmd(CMD_PROG, 7'h20, 16'h0010, ERASED, IDX_PROG, 16'h00A0, 0);
      // protection of program block 1 only
      wr(REG_PROTECT, 16'h0002);
      cmd(CMD_PROG, PF_BLK1, 16'h0030, 64'h0, IDX_PROG, 16'h0090, 0);
      cmd(CMD_PROG, PF_BLK0, 16'h0030, 64'h0, IDX_PROG, 16'h0080, 2);
      cmd(CMD_ALL, 7'h00, 16'h0000, 64'h0, IDX_ALL, 16'h0090, 0);
      cmd(CMD_BLK, PF_BLK1, 16'h0000, 64'h0, IDX_BLK, 16'h0090, 0);
      cmd(CMD_BLK, DF_BLK, 16'h0002, 64'h0, IDX_BLK, 16'h0080, 2);
      chk(opLog[0].op, OP_ERASE_BLK);
      chk(opLog[0].addr, {DF_BLK, 16'h0002});
      chk(opLog[1].op, OP_EVER_BLK);
      wr(REG_PROTECT, 16'h0000);
      // each command refused when its mode bit is off, and an unknown code
      for (int i = 0; i < 5; i++) begin
         wr(REG_MODE, 16'h000F ^ (16'h0001 << i));
         cmd(mCode[i], PF_BLK1, 16'h0000, ERASED, mIdx[i], 16'h00A0, 0);
      end
      wr(REG_MODE, 16'h000F);
      // one-time program: erased check, program, read back
      cmd(CMD_OTP, 7'h00, 16'h0003, ERASED, IDX_OTP, 16'h0080, 3);
      chk(opLog[0].op, OP_READ_OTP);
      chk(opLog[1].op, OP_PROG_OTP);
      chk(opLog[1].addr, 23'h000003);
      chk(opLog[2].op, OP_READ_OTP);
      chk(invSeen, 1'b1);
      chk(blk0ReadInvalid, 1'b0);
      cmd(CMD_OTP, 7'h00, 16'h0003, ERASED, IDX_OTP, 16'h0080, 3);
      otpRead = 64'h0000_0000_0000_1234;
      cmd(CMD_OTP, 7'h00, 16'h0003, ERASED, IDX_OTP, 16'h00A0, 1);
      cmd(CMD_OTP, 7'h00, 16'h0008, ERASED, IDX_OTP, 16'h00A0, 0);
      cmd(CMD_OTP, 7'h00, 16'h0007, ERASED, 3'h4, 16'h00A0, 0);
      // erase everything: bad index, failed verify, then a clean pass
      cmd(CMD_ALL, 7'h00, 16'h0000, 64'h0, 3'h1, 16'h00A0, 0);
      respFail = 1'b1;
      cmd(CMD_ALL, 7'h00, 16'h0000, 64'h0, IDX_ALL, 16'h0082, 2);
      chk(secured, 1'b1);
      respFail = 1'b0;
      cmd(CMD_ALL, 7'h00, 16'h0000, 64'h0, IDX_ALL, 16'h0080, 2);
      chk(opLog[0].op, OP_ERASE_ALL);
      chk(opLog[1].op, OP_EVER_ALL);
      chk(secured, 1'b0);
      // block erase refusals
      cmd(CMD_BLK, PF_BLK0, 16'h0000, 64'h0, 3'h0, 16'h00A0, 0);
      cmd(CMD_BLK, 7'h20, 16'h0000, 64'h0, IDX_BLK, 16'h00A0, 0);
      cmd(CMD_BLK, PF_BLK0, 16'h0004, 64'h0, IDX_BLK, 16'h00A0, 0);
      cmd(CMD_BLK, DF_BLK, 16'h0001, 64'h0, IDX_BLK, 16'h00A0, 0);
      results();
   end
endmodule // tb
